// File: verilog/atci_core.sv
// serial text command interpreter: escape entry, parsing, parameter sets, roles
`timescale 1ns/10ps
`default_nettype none
`include "atci_consts.svh"
module atci_core import atci_pkg::*;
#(
    parameter int MS_CYCLES  = `ATCI_MS_NS / `ATCI_CLK_NS,
    parameter int LINE_DEPTH = 32
)(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         nvRst,
    input  wire atci_byte_t   rxByte,
    output var  atci_byte_t   txByte,
    input  wire logic         txReady,
    output var  atci_byte_t   dataOut,
    input  wire logic         beaconValid,
    input  wire logic [63:0]  beaconExtId,
    output logic              joinAccept,
    output logic [63:0]       joinedExtId,
    output var  atci_role_t   role,
    output var  atci_params_t opParams,
    output logic              cmdMode,
    input  wire logic [7:0]   regAddr,
    input  wire logic [31:0]  regWdata,
    input  wire logic         regWr,
    input  wire logic         regRd,
    output logic [31:0]       regRdata
);
    localparam int IW = $clog2(LINE_DEPTH);
    localparam int MW = $clog2(MS_CYCLES + 1);
    localparam atci_params_t DEF = '{baud: `ATCI_DEF_BAUD, sleep: `ATCI_DEF_SLEEP,
        coord: `ATCI_DEF_COORD, dest: `ATCI_DEF_DEST, enc: `ATCI_DEF_ENC,
        timeout: `ATCI_DEF_TMO, guard: `ATCI_DEF_GUARD, esc: `ATCI_DEF_ESC,
        extId: `ATCI_DEF_EXTID};

    atci_state_t  state;
    atci_params_t pend;
    atci_params_t saved;
    logic         loadSaved;
    logic [MW-1:0] msCnt;
    logic         msTick;
    logic [15:0]  msIdle;
    logic [15:0]  escTimer;
    logic [1:0]   escCnt;
    logic [31:0]  cmdTimer;
    logic [IW:0]  lineLen;
    logic [IW:0]  idx;
    logic         parseErr;
    logic [15:0]  code;
    logic [63:0]  val;
    logic [4:0]   nDig;
    logic [7:0]   memQ;
    logic [7:0]   up;
    logic [3:0]   nib;
    logic         isHex;
    logic         exitAfter;
    logic         rplBusy;
    logic         escEnable;
    logic         timedOut;
    logic         rxEsc;
    // exec decode
    logic         known;
    logic         isParam;
    logic         hasParam;
    logic         execErr;
    logic [63:0]  rdVal;
    int           fieldW;
    logic [4:0]   rplNib;
    atci_reply_t  rplKind;
    atci_status_t status;

    atci_line_mem #(.WIDTH(8), .DEPTH(LINE_DEPTH)) lineMem (
        .clk_sys (clk_sys),
        .wrEn    (state == ATCI_ST_COLLECT && rxByte.valid && rxByte.data != `ATCI_CR
                  && lineLen < (IW+1)'(LINE_DEPTH)),
        .wrAddr  (lineLen[IW-1:0]),
        .wrData  (rxByte.data),
        .rdAddr  (idx[IW-1:0]),
        .rdData  (memQ)
    );

    atci_reply replyTx (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (state == ATCI_ST_RSTART),
        .kind    (rplKind),
        .value   (rdVal),
        .nibbles (rplNib),
        .txReady (txReady),
        .tx      (txByte),
        .busy    (rplBusy)
    );

    assign msTick   = (msCnt == MW'(MS_CYCLES - 1));
    assign timedOut = (cmdTimer >= 32'(opParams.timeout) * `ATCI_TO_UNIT_MS);
    assign rxEsc    = rxByte.valid && rxByte.data == opParams.esc;
    assign cmdMode  = !(state == ATCI_ST_IDLE || state == ATCI_ST_ESCWAIT);
    assign hasParam = (nDig != 5'h0);
    assign up       = (memQ >= `ATCI_CH_LA && memQ <= `ATCI_CH_LZ) ? memQ - `ATCI_CASE : memQ;
    assign isHex    = (up >= `ATCI_CH_0 && up <= `ATCI_CH_9) || (up >= `ATCI_CH_A && up <= `ATCI_CH_F);
    assign nib      = (up <= `ATCI_CH_9) ? 4'(up - `ATCI_CH_0) : 4'(up - `ATCI_HEXA);

    // roles follow the operating set only
    always_comb
    begin
        role.coord   = opParams.coord;
        role.endDev  = !opParams.coord && opParams.sleep != 8'h0;
        role.router  = !opParams.coord && opParams.sleep == 8'h0;
        role.sleepOk = role.endDev;
    end

    always_comb
    begin
        known   = 1'b1;
        isParam = 1'b1;
        rdVal   = '0;
        fieldW  = 0;
        unique case (code)
            `ATCI_CMD_APPLY, `ATCI_CMD_EXIT, `ATCI_CMD_SAVE: isParam = 1'b0;
            `ATCI_CMD_TMO:   begin rdVal = 64'(pend.timeout); fieldW = $bits(pend.timeout); end
            `ATCI_CMD_BAUD:  begin rdVal = 64'(pend.baud);    fieldW = $bits(pend.baud);    end
            `ATCI_CMD_SLEEP: begin rdVal = 64'(pend.sleep);   fieldW = $bits(pend.sleep);   end
            `ATCI_CMD_COORD: begin rdVal = 64'(pend.coord);   fieldW = $bits(pend.coord);   end
            `ATCI_CMD_DEST:  begin rdVal = pend.dest;         fieldW = $bits(pend.dest);    end
            `ATCI_CMD_ENC:   begin rdVal = 64'(pend.enc);     fieldW = $bits(pend.enc);     end
            `ATCI_CMD_GUARD: begin rdVal = 64'(pend.guard);   fieldW = $bits(pend.guard);   end
            `ATCI_CMD_ESC:   begin rdVal = 64'(pend.esc);     fieldW = $bits(pend.esc);     end
            `ATCI_CMD_EXTID: begin rdVal = pend.extId;        fieldW = $bits(pend.extId);   end
            default:         begin known = 1'b0; isParam = 1'b0; end
        endcase
        execErr = parseErr || !known;
        if (isParam && hasParam)
        begin
            if ((val >> fieldW) != 64'h0)
                execErr = 1'b1;
            if (code == `ATCI_CMD_SLEEP && val != 64'h0 && pend.coord)
                execErr = 1'b1;
            if (code == `ATCI_CMD_COORD && val != 64'h0 && pend.sleep != 8'h0)
                execErr = 1'b1;
        end
        else if (!isParam && hasParam)
            execErr = 1'b1;
        rplNib  = 5'((fieldW + 3) / 4);
        rplKind = execErr ? ATCI_RPL_ERR : (isParam && !hasParam) ? ATCI_RPL_VAL : ATCI_RPL_OK;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            msCnt <= '0;
        else
            msCnt <= msTick ? '0 : msCnt + MW'(1);
    end

    // silence and escape timers, saturating in ms
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            msIdle   <= '0;
            escTimer <= '0;
        end
        else
        begin
            if (rxByte.valid)
                msIdle <= '0;
            else if (msTick && msIdle != 16'hffff)
                msIdle <= msIdle + 16'h1;
            if (rxByte.valid && escCnt == 2'h0)
                escTimer <= '0;
            else if (msTick && escTimer != 16'hffff)
                escTimer <= escTimer + 16'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cmdTimer <= '0;
        else if (state == ATCI_ST_ESCWAIT || (state == ATCI_ST_EXEC && !execErr))
            cmdTimer <= '0;
        else if (msTick && cmdTimer != 32'hffff_ffff)
            cmdTimer <= cmdTimer + 32'h1;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state     <= ATCI_ST_IDLE;
            escCnt    <= '0;
            lineLen   <= '0;
            idx       <= '0;
            parseErr  <= 1'b0;
            code      <= '0;
            val       <= '0;
            nDig      <= '0;
            exitAfter <= 1'b0;
        end
        else
        begin
            unique case (state)
                ATCI_ST_IDLE:
                    if (rxByte.valid)
                    begin
                        if (!rxEsc || !escEnable)
                            escCnt <= '0;
                        else if (escCnt == 2'h0)
                            escCnt <= (msIdle >= opParams.guard) ? 2'h1 : 2'h0;
                        else if (escTimer >= opParams.guard)
                            escCnt <= '0;
                        else if (escCnt == `ATCI_ESC_COUNT - 2'h1)
                            state <= ATCI_ST_ESCWAIT;
                        else
                            escCnt <= escCnt + 2'h1;
                    end
                ATCI_ST_ESCWAIT:
                    if (rxByte.valid)
                    begin
                        escCnt <= '0;
                        state  <= ATCI_ST_IDLE;
                    end
                    else if (msIdle >= opParams.guard)
                    begin
                        escCnt    <= '0;
                        exitAfter <= 1'b0;
                        code      <= `ATCI_CMD_APPLY; // entry replies OK
                        nDig      <= '0;
                        parseErr  <= 1'b0;
                        state     <= ATCI_ST_RSTART;
                    end
                ATCI_ST_COLLECT:
                    if (timedOut)
                        state <= ATCI_ST_IDLE;
                    else if (rxByte.valid && rxByte.data == `ATCI_CR)
                    begin
                        idx      <= '0;
                        val      <= '0;
                        nDig     <= '0;
                        code     <= '0;
                        parseErr <= parseErr || lineLen < (IW+1)'(`ATCI_HDR_LEN);
                        state    <= (lineLen == '0) ? ATCI_ST_EXEC : ATCI_ST_FETCH;
                    end
                    else if (rxByte.valid)
                    begin
                        if (lineLen < (IW+1)'(LINE_DEPTH))
                            lineLen <= lineLen + (IW+1)'(1);
                        else
                            parseErr <= 1'b1; // overlong line answers ERROR
                    end
                ATCI_ST_FETCH:
                    state <= ATCI_ST_USE;
                ATCI_ST_USE:
                begin
                    if (idx == (IW+1)'(`ATCI_POS_A))
                        parseErr <= parseErr || up != `ATCI_CH_A;
                    else if (idx == (IW+1)'(`ATCI_POS_T))
                        parseErr <= parseErr || up != `ATCI_CH_T;
                    else if (idx == (IW+1)'(`ATCI_POS_CHI) || idx == (IW+1)'(`ATCI_POS_CLO))
                        code <= {code[7:0], up};
                    else if (!isHex || nDig == `ATCI_MAX_DIG)
                        parseErr <= 1'b1;
                    else
                    begin
                        val  <= {val[59:0], nib};
                        nDig <= nDig + 5'h1;
                    end
                    idx   <= idx + (IW+1)'(1);
                    state <= (idx + (IW+1)'(1) == lineLen) ? ATCI_ST_EXEC : ATCI_ST_FETCH;
                end
                ATCI_ST_EXEC:
                begin
                    exitAfter <= !execErr && code == `ATCI_CMD_EXIT;
                    state     <= ATCI_ST_RSTART;
                end
                ATCI_ST_RSTART:
                    state <= ATCI_ST_REPLY;
                ATCI_ST_REPLY:
                    if (!rplBusy)
                    begin
                        lineLen  <= '0;
                        parseErr <= 1'b0;
                        state    <= exitAfter ? ATCI_ST_IDLE : ATCI_ST_COLLECT;
                    end
            endcase
        end
    end

    // working set; a reset first reloads the stored copy
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pend      <= DEF;
            loadSaved <= 1'b1;
        end
        else if (loadSaved)
        begin
            pend      <= saved;
            loadSaved <= 1'b0;
        end
        else if (state == ATCI_ST_EXEC && !execErr && isParam && hasParam)
        begin
            unique case (code)
                `ATCI_CMD_TMO:   pend.timeout <= 16'(val);
                `ATCI_CMD_BAUD:  pend.baud    <= 8'(val);
                `ATCI_CMD_SLEEP: pend.sleep   <= 8'(val);
                `ATCI_CMD_COORD: pend.coord   <= val[0];
                `ATCI_CMD_DEST:  pend.dest    <= val;
                `ATCI_CMD_ENC:   pend.enc     <= 8'(val);
                `ATCI_CMD_GUARD: pend.guard   <= 16'(val);
                `ATCI_CMD_ESC:   pend.esc     <= 8'(val);
                `ATCI_CMD_EXTID: pend.extId   <= val;
                default:         pend         <= pend;
            endcase
        end
    end

    // operating set only moves on the reload after a reset, apply, exit or timeout
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            opParams <= DEF;
        else if (loadSaved)
            opParams <= saved;
        else if (state == ATCI_ST_EXEC && !execErr
                 && (code == `ATCI_CMD_APPLY || code == `ATCI_CMD_EXIT))
            opParams <= pend;
        else if (state == ATCI_ST_COLLECT && timedOut)
            opParams <= pend;
    end

    // stored copy survives the module reset, set back to the defaults only by power-on
    always_ff @(posedge clk_sys or posedge nvRst)
    begin
        if (nvRst)
            saved <= DEF;
        else if (state == ATCI_ST_EXEC && !execErr && code == `ATCI_CMD_SAVE)
            saved <= pend;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            dataOut <= '0;
        else
        begin
            dataOut.valid <= rxByte.valid && !cmdMode;
            dataOut.data  <= rxByte.data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            joinAccept  <= 1'b0;
            joinedExtId <= '0;
        end
        else
        begin
            joinAccept <= beaconValid
                && (opParams.extId == 64'h0 || beaconExtId == opParams.extId);
            if (beaconValid && (opParams.extId == 64'h0 || beaconExtId == opParams.extId))
                joinedExtId <= beaconExtId;
        end
    end

    assign status = '{cmdMode: cmdMode, escEnable: escEnable, role: role};

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            escEnable <= `ATCI_CTRL_RESET;
        else if (regWr && regAddr == `ATCI_REG_CTRL)
            escEnable <= regWdata[0];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            regRdata <= '0;
        else if (regRd)
        begin
            unique case (regAddr)
                `ATCI_REG_STATUS: regRdata <= 32'(status);
                `ATCI_REG_CTRL:   regRdata <= 32'(escEnable);
                `ATCI_REG_JOINLO: regRdata <= joinedExtId[31:0];
                `ATCI_REG_JOINHI: regRdata <= joinedExtId[63:32];
                default:          regRdata <= '0;
            endcase
        end
        else
            regRdata <= '0;
    end
endmodule
`default_nettype wire

// File: verilog/atci_consts.svh
// numeric constants of the serial text command interpreter
`ifndef ATCI_CONSTS_SVH
`define ATCI_CONSTS_SVH
`define ATCI_CLK_NS      8
`define ATCI_MS_NS       1000000
`define ATCI_TO_UNIT_MS  32'h0000_0064
`define ATCI_CR          8'h0d
`define ATCI_CH_A        8'h41
`define ATCI_CH_T        8'h54
`define ATCI_CH_0        8'h30
`define ATCI_CH_9        8'h39
`define ATCI_CH_F        8'h46
`define ATCI_CH_LA       8'h61
`define ATCI_CH_LZ       8'h7a
`define ATCI_CH_O        8'h4f
`define ATCI_CH_K        8'h4b
`define ATCI_CH_E        8'h45
`define ATCI_CH_R        8'h52
`define ATCI_CASE        8'h20
`define ATCI_HEXA        8'h37
`define ATCI_DEC_LIM     4'ha
`define ATCI_POS_A       0
`define ATCI_POS_T       1
`define ATCI_POS_CHI     2
`define ATCI_POS_CLO     3
`define ATCI_HDR_LEN     4
`define ATCI_MAX_DIG     5'h10
`define ATCI_OK_LAST     5'h02
`define ATCI_ERR_LAST    5'h04
`define ATCI_CMD_APPLY   16'h4150
`define ATCI_CMD_EXIT    16'h4558
`define ATCI_CMD_SAVE    16'h5356
`define ATCI_CMD_TMO     16'h544f
`define ATCI_CMD_BAUD    16'h4252
`define ATCI_CMD_SLEEP   16'h534c
`define ATCI_CMD_COORD   16'h434f
`define ATCI_CMD_DEST    16'h4441
`define ATCI_CMD_ENC     16'h454e
`define ATCI_CMD_GUARD   16'h4744
`define ATCI_CMD_ESC     16'h4553
`define ATCI_CMD_EXTID   16'h5849
`define ATCI_DEF_BAUD    8'h03
`define ATCI_DEF_SLEEP   8'h00
`define ATCI_DEF_COORD   1'h0
`define ATCI_DEF_DEST    64'h0
`define ATCI_DEF_ENC     8'h00
`define ATCI_DEF_TMO     16'h0064
`define ATCI_DEF_GUARD   16'h03e8
`define ATCI_DEF_ESC     8'h2b
`define ATCI_DEF_EXTID   64'h0
`define ATCI_ESC_COUNT   2'h3
`define ATCI_REG_STATUS  8'h00
`define ATCI_REG_CTRL    8'h04
`define ATCI_REG_JOINLO  8'h08
`define ATCI_REG_JOINHI  8'h0c
`define ATCI_CTRL_RESET  1'h1
`endif

// File: verilog/atci_pkg.sv
// types of the serial text command interpreter
package atci_pkg;
    typedef struct packed {
        logic [7:0]  baud;
        logic [7:0]  sleep;
        logic        coord;
        logic [63:0] dest;
        logic [7:0]  enc;
        logic [15:0] timeout;
        logic [15:0] guard;
        logic [7:0]  esc;
        logic [63:0] extId;
    } atci_params_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } atci_byte_t;
    typedef struct packed {
        logic coord;
        logic router;
        logic endDev;
        logic sleepOk;
    } atci_role_t;
    typedef struct packed {
        logic       cmdMode;
        logic       escEnable;
        atci_role_t role;
    } atci_status_t;
    typedef enum logic [1:0] {ATCI_RPL_OK, ATCI_RPL_ERR, ATCI_RPL_VAL} atci_reply_t;
    typedef enum logic [2:0] {
        ATCI_ST_IDLE, ATCI_ST_ESCWAIT, ATCI_ST_COLLECT, ATCI_ST_FETCH,
        ATCI_ST_USE, ATCI_ST_EXEC, ATCI_ST_RSTART, ATCI_ST_REPLY
    } atci_state_t;
endpackage

// File: verilog/atci_line_mem.sv
// line buffer memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module atci_line_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)(
    input  wire logic                     clk_sys,
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input  wire logic [WIDTH-1:0]         wrData,
    input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic      [WIDTH-1:0]         rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (wrEn)
            mem[wrAddr] <= wrData;
    end

    always_ff @(posedge clk_sys)
    begin
        rdData <= mem[rdAddr];
    end
endmodule
`default_nettype wire

// File: verilog/atci_reply.sv
// reply sender: OK, ERROR or a hex value, each closed by carriage return
`timescale 1ns/10ps
`default_nettype none
`include "atci_consts.svh"
module atci_reply import atci_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire atci_reply_t kind,
    input  wire logic [63:0] value,
    input  wire logic [4:0]  nibbles,
    input  wire logic        txReady,
    output var  atci_byte_t  tx,
    output logic             busy
);
    atci_reply_t kindQ;
    logic [63:0] valQ;
    logic [4:0]  nibQ;
    logic [4:0]  idx;
    logic [4:0]  lastIdx;

    function automatic logic [7:0] charAt(atci_reply_t k, logic [4:0] i,
                                          logic [63:0] v, logic [4:0] n);
        logic [3:0] d;
        logic [7:0] c;
        d = 4'(v >> {5'(n - i - 5'h01), 2'h0});
        c = `ATCI_CR;
        unique case (k)
            ATCI_RPL_OK:
                c = (i >= `ATCI_OK_LAST) ? `ATCI_CR : (i == 5'h0) ? `ATCI_CH_O : `ATCI_CH_K;
            ATCI_RPL_ERR:
                c = (i > `ATCI_ERR_LAST) ? `ATCI_CR : (i == 5'h0) ? `ATCI_CH_E :
                    (i == 5'h3) ? `ATCI_CH_O : `ATCI_CH_R;
            ATCI_RPL_VAL:
                if (i < n)
                    c = (d < `ATCI_DEC_LIM) ? `ATCI_CH_0 + 8'(d) : `ATCI_HEXA + 8'(d);
        endcase
        return c;
    endfunction

    always_comb
    begin
        unique case (kindQ)
            ATCI_RPL_OK:  lastIdx = `ATCI_OK_LAST;
            ATCI_RPL_ERR: lastIdx = `ATCI_ERR_LAST + 5'h1;
            default:      lastIdx = nibQ;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tx    <= '0;
            busy  <= 1'b0;
            idx   <= '0;
            kindQ <= ATCI_RPL_OK;
            valQ  <= '0;
            nibQ  <= '0;
        end
        else if (start && !busy)
        begin
            busy     <= 1'b1;
            kindQ    <= kind;
            valQ     <= value;
            nibQ     <= nibbles;
            idx      <= '0;
            tx.valid <= 1'b1;
            tx.data  <= charAt(kind, 5'h0, value, nibbles);
        end
        else if (tx.valid && txReady)
        begin
            if (idx == lastIdx)
            begin
                busy     <= 1'b0;
                tx.valid <= 1'b0;
            end
            else
            begin
                idx     <= idx + 5'h1;
                tx.data <= charAt(kindQ, idx + 5'h1, valQ, nibQ);
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/atci_core_properties.sv
// assertions on the interpreter top ports
`timescale 1ns/10ps
`default_nettype none
module atci_core_properties import atci_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rst,
    input wire atci_byte_t   rxByte,
    input wire atci_byte_t   txByte,
    input wire logic         txReady,
    input wire atci_byte_t   dataOut,
    input wire logic         beaconValid,
    input wire logic [63:0]  beaconExtId,
    input wire logic         joinAccept,
    input wire atci_role_t   role,
    input wire atci_params_t opParams,
    input wire logic         cmdMode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_join_filter: assert property (beaconValid |=> joinAccept ==
        ($past(opParams.extId) == 0 || $past(beaconExtId) == $past(opParams.extId))) else $error("join");
    a_role_coord: assert property (opParams.coord |->
        role.coord && !role.router && !role.sleepOk) else $error("coord role");
    a_role_end: assert property (!opParams.coord && opParams.sleep != 0 |->
        role.endDev && !role.router) else $error("end role");
    a_role_router: assert property (!opParams.coord && opParams.sleep == 0 |->
        role.router && !role.sleepOk) else $error("router role");
    a_op_hold: assert property (!cmdMode && !$past(cmdMode) && !$past(cmdMode, 2)
        && !$past(rst, 2) |-> $stable(opParams)) else $error("config moved");
    a_pass_data: assert property (rxByte.valid && !cmdMode |=>
        dataOut.valid && dataOut.data == $past(rxByte.data)) else $error("pass");
    a_no_pass: assert property (cmdMode && $past(cmdMode) |-> !dataOut.valid)
        else $error("leak");
    a_tx_hold: assert property (txByte.valid && !txReady |=>
        txByte.valid && $stable(txByte.data)) else $error("reply dropped");
endmodule
bind atci_core atci_core_properties atci_core_properties_inst (.clk_sys, .rst, .rxByte,
    .txByte, .txReady, .dataOut, .beaconValid, .beaconExtId, .joinAccept, .role, .opParams,
    .cmdMode);
`default_nettype wire

// File: verification/atci_host_model.sv
// host model: sends bytes, takes replies with random stalls
`timescale 1ns/10ps
`default_nettype none
module atci_host_model import atci_pkg::*;
(
    input  wire logic       clk_sys,
    output var  atci_byte_t rxByte,
    input  wire atci_byte_t txByte,
    output logic            txReady
);
    initial rxByte = '0;
    initial txReady = 1'b0;
    task automatic put(input logic [7:0] b);
        rxByte <= '{1'b1, b};
        @(posedge clk_sys);
        rxByte <= '{1'b0, ~b}; // idle line must not echo the byte
        @(posedge clk_sys);
    endtask
    task automatic grab(output logic [63:0] r);
        r = '0;
        for (int n = 0; n < 3000; n++)
        begin
            txReady <= 1'($random(tb_top.seed));
            @(posedge clk_sys);
            if (txByte.valid && txReady)
            begin
                r = {r[55:0], txByte.data};
                if (txByte.data == 8'h0d)
                begin
                    txReady <= 1'b0;
                    @(posedge clk_sys); // reply state drops bytes
                    return;
                end
            end
        end
        tb_top.error_cnt++;
        tb_top.conclude();
    endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// bench: host model, register and beacon stimulus, reference sets
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
$display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top import atci_pkg::*;
;
    localparam int MS = 2;
    logic         clk_sys = 0, rst = 1, nvRst = 1, beaconValid = 0, regWr = 0, regRd = 0;
    logic [7:0]   regAddr = '0;
    logic [31:0]  regWdata = '0, regRdata;
    logic [63:0]  beaconExtId = '0, reply, joinedExtId;
    logic         txReady, joinAccept, cmdMode;
    atci_byte_t   rxByte, txByte, dataOut;
    atci_role_t   role;
    atci_params_t opParams, pend, saved;
    int           error_cnt = 0, n_checks = 0, seed = 32'h96e9;
    atci_core #(.MS_CYCLES(MS), .LINE_DEPTH(32)) atci_core_inst (.clk_sys, .rst, .nvRst,
        .rxByte, .txByte, .txReady, .dataOut, .beaconValid, .beaconExtId, .joinAccept,
        .joinedExtId, .role, .opParams, .cmdMode, .regAddr, .regWdata, .regWr, .regRd, .regRdata);
    atci_host_model atci_host_model_inst (.clk_sys, .rxByte, .txByte, .txReady);
    initial forever #4 clk_sys = ~clk_sys;
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        error_cnt++;
        conclude;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        regWr <= w;
        regRd <= !w;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 0;
        regRd <= 0;
        @(posedge clk_sys);
        if (!w) `CHK(regRdata, d)
    endtask
    task automatic beacon(input logic [63:0] id, input logic acc);
        beaconValid <= 1;
        beaconExtId <= id;
        @(posedge clk_sys);
        beaconValid <= 0;
        @(posedge clk_sys);
        `CHK(joinAccept, acc)
    endtask
    task automatic cmd(input string s, input logic [63:0] e);
        foreach (s[i]) atci_host_model_inst.put(s[i]);
        atci_host_model_inst.put(8'h0d);
        atci_host_model_inst.grab(reply);
        `CHK(reply, e)
    endtask
    task automatic enter;
        repeat (1100 * MS) @(posedge clk_sys);
        repeat (3) atci_host_model_inst.put(8'h2b);
        atci_host_model_inst.grab(reply);
        `CHK(reply, "OK\015")
        `CHK(cmdMode, 1'b1)
    endtask
    task automatic idle(input int lim);
        for (int i = 0; i < lim && cmdMode; i++) @(posedge clk_sys);
        `CHK(cmdMode, 1'b0)
    endtask
    task automatic pulse_reset;
        rst <= 1;
        @(posedge clk_sys);
        rst <= 0;
        repeat (2) @(posedge clk_sys);
    endtask
    initial
    begin
        @(posedge clk_sys);
        nvRst <= 0;
        pulse_reset;
        pend = {8'h03, 8'h00, 1'b0, 64'h0, 8'h00, 16'h0064, 16'h03e8, 8'h2b, 64'h0};
        `CHK(opParams, pend)
        repeat (20) atci_host_model_inst.put(8'($random(seed)));
        reply = {$random(seed), $random(seed)};
        beacon(reply, 1'b1);
        `CHK(joinedExtId, reply)
        bus(0, 8'h00, 32'h14);
        bus(0, 8'h08, reply[31:0]);
        bus(1, 8'h04, 32'h0);
        bus(0, 8'h00, 32'h04);
        bus(1, 8'h04, 32'h1);
        bus(0, 8'h40, 32'h0);
        $display("test idle done");
        enter;
        cmd("ATBR5", "OK\015");
        `CHK(opParams, pend)
        cmd("ATBR", "05\015");
        cmd("ATZZ", "ERROR\015");
        cmd("ATCO1", "OK\015");
        cmd("ATSL1", "ERROR\015");
        cmd("ATAP", "OK\015");
        pend.baud = 8'h05;
        pend.coord = 1'b1;
        `CHK(opParams, pend)
        cmd("ATCO0", "OK\015");
        cmd("ATSL2", "OK\015");
        cmd("ATXI1234", "OK\015");
        cmd("ATEN8", "OK\015");
        cmd("ATSV", "OK\015");
        cmd("ATEX", "OK\015");
        idle(20);
        pend.coord = 1'b0;
        pend.sleep = 8'h02;
        pend.extId = 64'h1234;
        pend.enc = 8'h08;
        saved = pend;
        `CHK(opParams, pend)
        `CHK(role.sleepOk, 1'b1)
        beacon(64'h1234, 1'b1);
        beacon(64'h1235, 1'b0);
        $display("test session done");
        pulse_reset;
        `CHK(opParams, saved)
        enter;
        cmd("ATDA7", "OK\015");
        cmd("ATTO1", "OK\015");
        cmd("ATAP", "OK\015");
        pend.dest = 64'h7;
        pend.timeout = 16'h1;
        repeat (75 * MS) @(posedge clk_sys);
        cmd("ATBR5", "OK\015");
        repeat (75 * MS) @(posedge clk_sys);
        `CHK(cmdMode, 1'b1)
        idle(100 * MS);
        `CHK(opParams, pend)
        pulse_reset;
        `CHK(opParams, saved)
        $display("test timeout done");
        conclude;
    end
endmodule
`default_nettype wire
